/* File: design/mmb_cnt_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface mmb_cnt_if #(
  parameter int WIDTH = 16
);
  logic             run;
  logic [WIDTH-1:0] count;

  modport ctl (output run, input count);
  modport cnt (input run, output count);
endinterface

`default_nettype wire

/* File: design/mmb_defs.svh */
`ifndef MMB_DEFS_SVH
`define MMB_DEFS_SVH

// timing base
`define MMB_CLK_PERIOD_NS   1000000 / 100000
`define MMB_TICK_PERIOD_NS  1000000
`define MMB_TIME_W          16
`define MMB_MIN_SENSOR_MS   16'h0096
`define MMB_WIN_MIN_MS      16'h07d0
`define MMB_WIN_MAX_MS      16'h1388
`define MMB_TIMEOUT_MIN_MS  16'h2710
`define MMB_BLIND_MIN_MS    16'h00fa
`define MMB_BLIND_MAX_MS    16'h03e8
`define MMB_END_MIN_MS      16'h09c4
`define MMB_END_MAX_MS      16'h1770
`define MMB_NO_LIMIT        16'h0000

// register offsets
`define MMB_OFS_CTRL        8'h00
`define MMB_OFS_WINDOW      8'h04
`define MMB_OFS_TIMEOUT     8'h08
`define MMB_OFS_BLIND       8'h0c
`define MMB_OFS_ENDTIME     8'h10
`define MMB_OFS_STATUS      8'h14

// control fields
`define MMB_CTRL_W          8
`define MMB_CTRL_RESET      8'h00
`define MMB_CTRL_TWODET     0
`define MMB_CTRL_ENOPT      1
`define MMB_CTRL_ENMODE     2
`define MMB_CTRL_DIR_LO     3
`define MMB_CTRL_DIR_HI     4
`define MMB_CTRL_CLOSE      5
`define MMB_CTRL_BLINDEN    6
`define MMB_CTRL_MINEN      7

// status fields
`define MMB_STAT_STATE_LO   0
`define MMB_STAT_STATE_HI   2
`define MMB_STAT_MUTING     3
`define MMB_STAT_OUT        4
`define MMB_STAT_ARMED      5
`define MMB_STAT_FWD        6
`define MMB_STAT_READY      7

// time register resets
`define MMB_WINDOW_RESET    16'h07d0
`define MMB_TIMEOUT_RESET   16'h2710
`define MMB_BLIND_RESET     16'h00fa
`define MMB_END_RESET       16'h09c4

`endif

/* File: design/mmb_material_muting.sv */
// What this block does
// - simultaneous mode mutes when entering pair both interrupt within the sensor window
// - simultaneous start only with all four detectors clear and guard true
// - abort muting at once when cycle timeout expires; zero means no limit
// - without enable option muting is always enabled; otherwise enable gates starts
// - arm/disarm mode needs an enable rising edge; static levels never start
// - arm/disarm mode ends muting on enable falling edge in any state
// - arm-only mode never ends muting by enable; partner returns enable low
// - direction setting selects forward, reverse or both travel orders
// - curtain closing ends muting on guard rising transition
// - sensor closing ends muting when third detector of travel clears
// - simultaneous curtain mode holds guard true for blind time after muting
// - minimum sensor time requires more than 150 ms between pair activations
// - while muting, guard interruption does not drop the output
// - two-detector mode uses a and b, both within the sensor window
// - two-detector start only with a and b clear and guard true
// - two-detector mode ends muting once the opening is cleared
// - two-detector mode ends muting when end time from first detector elapses
// - two-detector mode holds guard true for blind time after muting
//
// The implementer's own choices: the address map and the APB register port.
`include "mmb_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module mmb_material_muting #(
  parameter int TICK_CYCLES = `MMB_TICK_PERIOD_NS / (`MMB_CLK_PERIOD_NS),
  parameter int TIME_W      = `MMB_TIME_W
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        detectorA,
  input  wire logic        detectorB,
  input  wire logic        detectorC,
  input  wire logic        detectorD,
  input  wire logic        guardIn,
  input  wire logic        enableIn,
  output var  logic        operatorOut,
  output var  logic        mutingActive
);

  generate
    if (TICK_CYCLES < 1 || TIME_W != `MMB_TIME_W) begin : gBad
      $error("mmb_material_muting: unsupported parameter values");
    end
  endgenerate

  // reset release
  logic rstSync1_reg;
  logic rstSync2_reg;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  wire logic rstn = rstSync2_reg;

  // pin synchronisers
  logic [5:0] pinSync1_reg;
  logic [5:0] pinSync2_reg;
  wire  logic [5:0] pinRaw = {enableIn, guardIn, detectorD, detectorC, detectorB, detectorA};
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinSync1_reg <= 6'h00;
      pinSync2_reg <= 6'h00;
    end else begin
      pinSync1_reg <= pinRaw;
      pinSync2_reg <= pinSync1_reg;
    end
  end

  wire logic [3:0] det   = pinSync2_reg[3:0];
  wire logic       guard = pinSync2_reg[4];
  wire logic       en    = pinSync2_reg[5];

  logic guardPrev_reg;
  logic enPrev_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      guardPrev_reg <= 1'b0;
      enPrev_reg    <= 1'b0;
    end else begin
      guardPrev_reg <= guard;
      enPrev_reg    <= en;
    end
  end
  wire logic guardRise = guard & ~guardPrev_reg;
  wire logic enRise    = en & ~enPrev_reg;
  wire logic enFall    = ~en & enPrev_reg;

  // timebase tick
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  logic [31:0] tickDiv_reg;
  logic        tick_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tickDiv_reg <= 32'h0000_0000;
      tick_reg    <= 1'b0;
    end else if (tickDiv_reg == TICK_LAST) begin
      tickDiv_reg <= 32'h0000_0000;
      tick_reg    <= 1'b1;
    end else begin
      tickDiv_reg <= tickDiv_reg + 32'h0000_0001;
      tick_reg    <= 1'b0;
    end
  end

  // configuration registers
  logic [`MMB_CTRL_W-1:0] ctrl_reg;
  logic [TIME_W-1:0]      window_reg;
  logic [TIME_W-1:0]      timeout_reg;
  logic [TIME_W-1:0]      blind_reg;
  logic [TIME_W-1:0]      endTime_reg;

  wire logic twoDet     = ctrl_reg[`MMB_CTRL_TWODET];
  wire logic enOpt      = ctrl_reg[`MMB_CTRL_ENOPT];
  wire logic armOnly    = ctrl_reg[`MMB_CTRL_ENMODE];
  wire logic closeSens  = ctrl_reg[`MMB_CTRL_CLOSE];
  wire logic blindEn    = ctrl_reg[`MMB_CTRL_BLINDEN];
  wire logic minEn      = ctrl_reg[`MMB_CTRL_MINEN];
  wire mmb_pkg::mmb_dir_type dirSel =
    mmb_pkg::mmb_dir_type'(ctrl_reg[`MMB_CTRL_DIR_HI:`MMB_CTRL_DIR_LO]);

  function automatic logic [15:0] clampMs(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // apb decode
  wire logic apbSetup  = psel & ~penable;
  wire logic apbAccess = psel & penable;
  wire logic selCtrl   = (paddr == `MMB_OFS_CTRL);
  wire logic selWin    = (paddr == `MMB_OFS_WINDOW);
  wire logic selTo     = (paddr == `MMB_OFS_TIMEOUT);
  wire logic selBlind  = (paddr == `MMB_OFS_BLIND);
  wire logic selEnd    = (paddr == `MMB_OFS_ENDTIME);
  wire logic selStat   = (paddr == `MMB_OFS_STATUS);
  wire logic mapped    = selCtrl | selWin | selTo | selBlind | selEnd | selStat;
  wire logic wrEn      = apbAccess & pwrite & mapped;
  wire logic [15:0] wrTime = pwdata[15:0];
  wire logic [15:0] toMs   = (wrTime == `MMB_NO_LIMIT) ? `MMB_NO_LIMIT :
                             clampMs(wrTime, `MMB_TIMEOUT_MIN_MS, 16'hffff);

  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~mapped;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg    <= `MMB_CTRL_RESET;
      window_reg  <= `MMB_WINDOW_RESET;
      timeout_reg <= `MMB_TIMEOUT_RESET;
      blind_reg   <= `MMB_BLIND_RESET;
      endTime_reg <= `MMB_END_RESET;
    end else if (wrEn) begin
      if (selCtrl) ctrl_reg <= pwdata[`MMB_CTRL_W-1:0];
      if (selWin) window_reg <= clampMs(wrTime, `MMB_WIN_MIN_MS, `MMB_WIN_MAX_MS);
      if (selTo) timeout_reg <= toMs;
      if (selBlind) blind_reg <= clampMs(wrTime, `MMB_BLIND_MIN_MS, `MMB_BLIND_MAX_MS);
      if (selEnd) endTime_reg <= clampMs(wrTime, `MMB_END_MIN_MS, `MMB_END_MAX_MS);
    end
  end

  // sequence state
  mmb_pkg::mmb_state_type state_reg;
  mmb_pkg::mmb_state_type state_next;
  logic fwd_reg;
  logic fwd_next;
  logic ready_reg;
  logic ready_next;
  logic armed_reg;
  logic armed_next;
  logic thirdSeen_reg;
  logic thirdSeen_next;
  logic out_reg;

  mmb_cnt_if #(.WIDTH(TIME_W)) winIf ();
  mmb_cnt_if #(.WIDTH(TIME_W)) cycIf ();
  mmb_cnt_if #(.WIDTH(TIME_W)) blindIf ();

  mmb_tick_counter #(.WIDTH(TIME_W)) uWinCnt (
    .clk  (core_clk),
    .rstn (rstn),
    .tick (tick_reg),
    .cnt  (winIf.cnt)
  );
  mmb_tick_counter #(.WIDTH(TIME_W)) uCycCnt (
    .clk  (core_clk),
    .rstn (rstn),
    .tick (tick_reg),
    .cnt  (cycIf.cnt)
  );
  mmb_tick_counter #(.WIDTH(TIME_W)) uBlindCnt (
    .clk  (core_clk),
    .rstn (rstn),
    .tick (tick_reg),
    .cnt  (blindIf.cnt)
  );

  wire logic inFirst = (state_reg == mmb_pkg::FIRST);
  wire logic inMute  = (state_reg == mmb_pkg::MUTE);
  wire logic inBlind = (state_reg == mmb_pkg::BLIND);
  wire logic inIdle  = (state_reg == mmb_pkg::IDLE);

  // window counter runs on through muting for the end time
  assign winIf.run   = inFirst | inMute;
  assign cycIf.run   = inMute;
  assign blindIf.run = inBlind;

  // entering pair and third detector follow direction
  wire logic fwdOk   = (dirSel != mmb_pkg::DIR_REV);
  wire logic revOk   = ~twoDet & (dirSel != mmb_pkg::DIR_FWD);
  wire logic startFw = fwdOk & (det[0] | det[1]);
  wire logic startRv = revOk & (det[3] | det[2]);
  wire logic entA    = fwd_reg ? det[0] : det[3];
  wire logic entB    = fwd_reg ? det[1] : det[2];
  wire logic thirdDt = fwd_reg ? det[2] : det[1];
  wire logic pairAll = entA & entB;
  wire logic pairNo  = ~entA & ~entB;

  // all four clear in simultaneous mode
  // only a and b in two-detector mode
  wire logic allClear = twoDet ? ~(det[0] | det[1]) : ~|det;

  // no enable option means permanently enabled
  wire logic enableOk = ~enOpt | armed_reg;
  // falling enable disarms in arm/disarm mode
  wire logic disarm   = enOpt & ~armOnly & enFall;

  wire logic winOver  = (winIf.count > window_reg);
  // strictly more than the minimum separation
  wire logic tooFast  = minEn & (winIf.count <= `MMB_MIN_SENSOR_MS);
  wire logic timedOut = (timeout_reg != `MMB_NO_LIMIT) &
                        (cycIf.count >= timeout_reg);
  wire logic endElap  = (winIf.count >= endTime_reg);
  wire logic blindUp  = (blindIf.count >= blind_reg);

  // opening cleared ends the two-detector cycle
  // end time elapsed ends the two-detector cycle
  wire logic closeTwo = (allClear & guard) | endElap;
  // sensor closing on third detector clearing
  wire logic closeSim = closeSens ? (thirdSeen_reg & ~thirdDt) : guardRise;
  wire logic closeEv  = twoDet ? closeTwo : closeSim;
  // blind only with curtain closing in simultaneous mode
  // blind always allowed in two-detector mode
  wire logic blindOk  = blindEn & (twoDet | ~closeSens);

  always_comb begin
    state_next     = state_reg;
    fwd_next       = fwd_reg;
    ready_next     = 1'b0;
    thirdSeen_next = 1'b0;
    case (state_reg)
      mmb_pkg::IDLE: begin
        ready_next = ready_reg | (allClear & guard);
        // either detector of a pair may come first
        // with the enable option, start only once armed by an enable edge
        if (ready_reg && enableOk && (startFw || startRv)) begin
          state_next = mmb_pkg::FIRST;
          fwd_next   = startFw;
          ready_next = 1'b0;
        end
      end
      mmb_pkg::FIRST: begin
        if (disarm || winOver || pairNo) begin
          state_next = mmb_pkg::IDLE;
        end else if (pairAll) begin
          state_next = tooFast ? mmb_pkg::IDLE : mmb_pkg::MUTE;
        end
      end
      mmb_pkg::MUTE: begin
        thirdSeen_next = thirdSeen_reg | thirdDt;
        if (timedOut || disarm) begin
          state_next = mmb_pkg::IDLE;
        end else if (closeEv) begin
          state_next = blindOk ? mmb_pkg::BLIND : mmb_pkg::IDLE;
        end
      end
      mmb_pkg::BLIND: begin
        if (blindUp || disarm) begin
          state_next = mmb_pkg::IDLE;
        end
      end
      default: begin
        state_next = mmb_pkg::IDLE;
      end
    endcase
  end

  wire logic muteStart = inFirst & (state_next == mmb_pkg::MUTE);

  // rising edge arms, set wins over consumption
  always_comb begin
    armed_next = armed_reg;
    if (!enOpt) begin
      armed_next = 1'b0;
    end else if (enRise) begin
      armed_next = 1'b1;
    end else if (muteStart || disarm) begin
      armed_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= mmb_pkg::IDLE;
      fwd_reg       <= 1'b1;
      ready_reg     <= 1'b0;
      armed_reg     <= 1'b0;
      thirdSeen_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      fwd_reg       <= fwd_next;
      ready_reg     <= ready_next;
      armed_reg     <= armed_next;
      thirdSeen_reg <= thirdSeen_next;
    end
  end

  // muting and blind time bypass the guard
  // registered OR of guard, muting and blind time
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_reg      <= 1'b0;
      mutingActive <= 1'b0;
    end else begin
      out_reg      <= guard | inMute | inBlind;
      mutingActive <= inMute;
    end
  end
  assign operatorOut = out_reg;

  // status and read data
  wire logic [7:0] statusBits = {ready_reg, fwd_reg, armed_reg, out_reg,
                                 mutingActive, 3'(state_reg)};
  wire logic [31:0] rdMux =
    selCtrl  ? {24'h00_0000, ctrl_reg} :
    selWin   ? {16'h0000, window_reg} :
    selTo    ? {16'h0000, timeout_reg} :
    selBlind ? {16'h0000, blind_reg} :
    selEnd   ? {16'h0000, endTime_reg} :
    selStat  ? {24'h00_0000, statusBits} : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (apbSetup && !pwrite) begin
      prdata <= rdMux;
    end
  end

endmodule

`default_nettype wire

/* File: design/mmb_pkg.sv */
package mmb_pkg;

  typedef enum logic [2:0] {
    IDLE,
    FIRST,
    MUTE,
    BLIND
  } mmb_state_type;

  typedef enum logic [1:0] {
    DIR_BOTH,
    DIR_FWD,
    DIR_REV,
    DIR_SPARE
  } mmb_dir_type;

endpackage

/* File: design/mmb_tick_counter.sv */
`timescale 1ns/1ns
`default_nettype none

module mmb_tick_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic tick,
  mmb_cnt_if.cnt    cnt
);

  localparam logic [WIDTH-1:0] CNT_MAX = '1;

  generate
    if (WIDTH < 2) begin : gBad
      $error("mmb_tick_counter: WIDTH too small");
    end
  endgenerate

  wire logic atMax = (cnt.count == CNT_MAX);

  // counts ticks while running, held at zero otherwise, saturates
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt.count <= '0;
    end else if (!cnt.run) begin
      cnt.count <= '0;
    end else if (tick && !atMax) begin
      cnt.count <= cnt.count + 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: test/mmb_field_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mmb_field_model (
  input  wire logic core_clk,
  output logic      detectorA,
  output logic      detectorB,
  output logic      detectorC,
  output logic      detectorD,
  output logic      guardIn,
  output logic      enableIn
);
  initial {enableIn, guardIn, detectorD, detectorC, detectorB, detectorA} = 6'h10;
  task automatic drive(input logic [5:0] v);
    @(posedge core_clk);
    {enableIn, guardIn, detectorD, detectorC, detectorB, detectorA} <= v;
  endtask
endmodule
`default_nettype wire

/* File: test/mmb_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module mmb_monitor #(
  parameter int TICK_CYCLES = 1
) (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        detectorA,
  input wire logic        detectorB,
  input wire logic        detectorC,
  input wire logic        detectorD,
  input wire logic        guardIn,
  input wire logic        enableIn,
  input wire logic        operatorOut,
  input wire logic        mutingActive
);
  logic [7:0]  ctrlReg;
  logic [15:0] toReg;
  logic [15:0] endReg;
  logic [31:0] muteLen;
  logic [3:0]  h1;
  logic [3:0]  h2;
  logic [3:0]  h3;
  wire         wr     = psel && penable && pwrite && pready;
  wire  [3:0]  seen   = h1 | h2 | h3;
  wire  [31:0] toCap  = 32'(toReg) * TICK_CYCLES + 32'h0000_0008;
  wire  [31:0] endCap = 32'(endReg) * TICK_CYCLES + 32'h0000_0008;
  // shadow of the written settings, muting length and detector history
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlReg <= 8'h00;
      toReg <= 16'h2710;
      endReg <= 16'h09c4;
      muteLen <= 32'h0000_0000;
      h1 <= 4'h0;
      h2 <= 4'h0;
      h3 <= 4'h0;
    end else begin
      if (wr && paddr == 8'h00) ctrlReg <= pwdata[7:0];
      if (wr && paddr == 8'h08) toReg <= pwdata[15:0];
      if (wr && paddr == 8'h10) endReg <= pwdata[15:0];
      muteLen <= mutingActive ? muteLen + 32'h0000_0001 : 32'h0000_0000;
      h1 <= {detectorD, detectorC, detectorB, detectorA};
      h2 <= h1;
      h3 <= h2;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  mute_out_a: assert property (
    mutingActive |-> operatorOut) else $error("output low while muting");
  guard_pass_a: assert property (
    guardIn [*6] |=> operatorOut) else $error("output low with guard clear");
  pair_seen_a: assert property (
    $rose(mutingActive) |-> (seen[0] && seen[1]) || (seen[2] && seen[3]))
    else $error("muting without a full pair");
  rev_pair_a: assert property (
    ctrlReg[4:3] == 2'b10 && !ctrlReg[0] && $rose(mutingActive) |-> seen[3] && seen[2])
    else $error("reverse mode started on forward pair");
  disarm_end_a: assert property (
    ctrlReg[2:1] == 2'b01 && mutingActive && $fell(enableIn) |-> ##[1:8] !mutingActive)
    else $error("muting kept after disarm");
  timeout_cap_a: assert property (
    toReg != 16'h0000 |-> muteLen <= toCap) else $error("muting beyond timeout");
  end_cap_a: assert property (
    ctrlReg[0] |-> muteLen <= endCap) else $error("muting beyond end time");
  curtain_close_a: assert property (
    !ctrlReg[0] && !ctrlReg[5] && mutingActive && $rose(guardIn) |-> ##[1:8] !mutingActive)
    else $error("guard rise did not end muting");
  err_access_a: assert property (
    pslverr |-> psel && penable) else $error("error outside access phase");
  cover property ($rose(mutingActive));
  cover property ($fell(mutingActive) && ctrlReg[0]);
  cover property (pslverr);
endmodule
bind mmb_material_muting mmb_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .detectorA(detectorA), .detectorB(detectorB),
  .detectorC(detectorC), .detectorD(detectorD), .guardIn(guardIn),
  .enableIn(enableIn), .operatorOut(operatorOut), .mutingActive(mutingActive));
`default_nettype wire

/* File: test/test_material_muting_bypass.sv */
`timescale 1ns/1ns
`default_nettype none
module test_material_muting_bypass;
  logic        core_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        detectorA;
  logic        detectorB;
  logic        detectorC;
  logic        detectorD;
  logic        guardIn;
  logic        enableIn;
  logic        operatorOut;
  logic        mutingActive;
  logic        enBit;
  int          bad_count;
  int          cmp_count;
  int          cycles;
  logic [7:0]  rowCtrl [7] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h10, 8'h10, 8'h18};
  logic [5:0]  rowOne  [7] = '{6'h11, 6'h18, 6'h11, 6'h18, 6'h11, 6'h18, 6'h18};
  logic        rowExp  [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [31:0] regRst  [5] = '{32'h0000_0000, 32'h0000_07d0, 32'h0000_2710,
                               32'h0000_00fa, 32'h0000_09c4};
  mmb_material_muting #(.TICK_CYCLES(1)) DUT (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .detectorA(detectorA),
    .detectorB(detectorB), .detectorC(detectorC), .detectorD(detectorD),
    .guardIn(guardIn), .enableIn(enableIn), .operatorOut(operatorOut),
    .mutingActive(mutingActive));
  mmb_field_model fld (
    .core_clk(core_clk), .detectorA(detectorA), .detectorB(detectorB),
    .detectorC(detectorC), .detectorD(detectorD), .guardIn(guardIn),
    .enableIn(enableIn));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      $display("[FAIL] %0t run too long", $time);
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    #1;
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h", $time, m, got);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0000_0000, r, e);
    chk(r, x, "read data");
    chk(32'(e), 32'(xe), "slave error");
  endtask
  task automatic pin(input logic [5:0] v, input int n);
    fld.drive(v | {enBit, 5'h00});
    repeat (n) @(posedge core_clk);
  endtask
  task automatic enter(input logic [5:0] one, input logic [5:0] two, input int gap);
    pin(6'h10, 10);
    pin(one, gap);
    pin(two, 10);
  endtask
  task automatic leave;
    pin(6'h0c, 10);
    pin(6'h1c, 10);
    pin(6'h10, 10);
  endtask
  task automatic mute(input logic x);
    chk(32'(mutingActive), 32'(x), "muting state");
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, enBit} = '0;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    resetn = 1'b0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), regRst[i], 1'b0);
    rd(8'h18, 32'h0000_0000, 1'b1);
    rd(8'h14, 32'h0000_00d0, 1'b0);
    wr(8'h04, 32'h0000_0064);
    rd(8'h04, 32'h0000_07d0, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, 32'(rowCtrl[i]));
      enter(rowOne[i], rowOne[i] | 6'h13 & {4'h1, rowOne[i][0], 1'b1} | 6'h04, 200);
      mute(rowExp[i]);
      leave();
    end
    $display("test directions done");
    wr(8'h00, 32'h0000_0000);
    enter(6'h11, 6'h13, 200);
    pin(6'h03, 10);
    chk(32'(operatorOut), 32'h0000_0001, "output with guard cut");
    pin(6'h0f, 10);
    pin(6'h1c, 10);
    mute(1'b0);
    enter(6'h11, 6'h13, 2100);
    mute(1'b0);
    pin(6'h14, 10);
    pin(6'h15, 200);
    pin(6'h17, 10);
    mute(1'b0);
    enter(6'h11, 6'h13, 200);
    pin(6'h03, 9900);
    mute(1'b1);
    pin(6'h03, 120);
    mute(1'b0);
    pin(6'h10, 10);
    $display("test curtain and timeout done");
    wr(8'h00, 32'h0000_0080);
    enter(6'h11, 6'h13, 50);
    mute(1'b0);
    enter(6'h11, 6'h13, 200);
    mute(1'b1);
    leave();
    wr(8'h00, 32'h0000_0002);
    enter(6'h11, 6'h13, 200);
    mute(1'b0);
    enBit = 1'b1;
    enter(6'h11, 6'h13, 200);
    mute(1'b1);
    enBit = 1'b0;
    pin(6'h13, 10);
    mute(1'b0);
    enBit = 1'b1;
    enter(6'h11, 6'h13, 200);
    leave();
    enter(6'h11, 6'h13, 200);
    mute(1'b0);
    leave();
    enBit = 1'b0;
    pin(6'h10, 10);
    wr(8'h00, 32'h0000_0006);
    enBit = 1'b1;
    enter(6'h11, 6'h13, 200);
    enBit = 1'b0;
    pin(6'h13, 10);
    mute(1'b1);
    leave();
    $display("test enable done");
    wr(8'h00, 32'h0000_0020);
    enter(6'h11, 6'h13, 200);
    pin(6'h1f, 10);
    pin(6'h1c, 10);
    mute(1'b1);
    pin(6'h18, 10);
    mute(1'b0);
    wr(8'h00, 32'h0000_0040);
    enter(6'h11, 6'h13, 200);
    pin(6'h0c, 10);
    pin(6'h1c, 3);
    pin(6'h0c, 100);
    chk(32'(operatorOut), 32'h0000_0001, "blind hold");
    pin(6'h0c, 300);
    chk(32'(operatorOut), 32'h0000_0000, "blind over");
    $display("test sensor and blind done");
    wr(8'h00, 32'h0000_0001);
    enter(6'h11, 6'h13, 200);
    mute(1'b1);
    pin(6'h03, 10);
    pin(6'h10, 10);
    mute(1'b0);
    enter(6'h11, 6'h13, 200);
    pin(6'h03, 2000);
    mute(1'b1);
    pin(6'h03, 400);
    mute(1'b0);
    pin(6'h00, 10);
    pin(6'h01, 200);
    pin(6'h03, 10);
    mute(1'b0);
    $display("test two detector done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
